// [cst_trigger.sv]
// cst_trigger.sv: clocked state trigger with holdoff and auto mode.
// assumes probed pins asynchronous; settings static from core logic.
`timescale 1ns/1ns
// Function
// - after holdoff, wait for selected clock edge
// - compare seventeen inputs, skip don't-care
// - true result triggers immediately
// - and: every compared input matches
// - nand: at least one mismatch
// - or: at least one match
// - nor: every compared input mismatches
// - all don't-care pattern never triggers
// - clock source excluded from pattern
// - clock source is any of the seventeen inputs
// - polarity command toggles edge choice
// - writing a level decrements the pointer
// - auto mode acquires after timeout
// - normal mode acquires only on trigger
// - holdoff in percent, main system only
module cst_trigger #(
   parameter int AUTO_CYC = cst_pkg::AUTO_TIMEOUT_CYC,
   parameter int CNT_W = 24
) (
   core_clk,
   reset_n,
   probe_in,
   clk_src_sel,
   polarity_cmd,
   func_sel,
   auto_mode,
   holdoff_pct,
   ptr_load,
   ptr_load_val,
   set_high_cmd,
   set_low_cmd,
   clear_position_command,
   pattern_position_pointer,
   rising_edge_sel,
   trigger_pulse,
   acquire_start,
   holdoff_busy,
   pattern_valid
);
   input wire logic core_clk;
   input wire logic reset_n;
   input wire logic [16:0] probe_in;
   input wire logic [4:0] clk_src_sel;
   input wire logic polarity_cmd;
   input wire logic [1:0] func_sel;
   input wire logic auto_mode;
   input wire logic [6:0] holdoff_pct;
   input wire logic ptr_load;
   input wire logic [4:0] ptr_load_val;
   input wire logic set_high_cmd;
   input wire logic set_low_cmd;
   input wire logic clear_position_command;
   output logic [4:0] pattern_position_pointer;
   output logic rising_edge_sel;
   output logic trigger_pulse;
   output logic acquire_start;
   output logic holdoff_busy;
   output logic pattern_valid;

   localparam logic [CNT_W-1:0] STEP_CYC =
      CNT_W'(cst_pkg::HOLDOFF_STEP_CYC);
   localparam logic [CNT_W-1:0] AUTO_LOAD = CNT_W'(AUTO_CYC - 1);

   logic [16:0] pin_s;
   logic [1:0] pat_ff [cst_pkg::NUM_IN];
   logic [1:0] nxt_pat [cst_pkg::NUM_IN];
   logic [4:0] ptr_ff, nxt_ptr;
   logic rise_ff, nxt_rise;
   logic clk_prev_ff, nxt_clk_prev;
   logic [CNT_W-1:0] hold_ff, nxt_hold;
   logic [CNT_W-1:0] auto_ff, nxt_auto;
   logic trig_ff, nxt_trig;
   logic acq_ff, nxt_acq;
   logic [16:0] care, match, miss;
   logic clk_now, edge_hit, any_care, fn_true;
   logic [1:0] wr_lvl;
   logic wr_any;
   logic [6:0] hold_pct;

   // =========================================
   // pin synchroniser
   cst_sync #(.W(cst_pkg::NUM_IN)) u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .async_in(probe_in),
      .sync_out(pin_s)
   );

   // =========================================
   // per-position compare, clock source masked
   genvar gi;
   generate
      for (gi = 0; gi < cst_pkg::NUM_IN; gi++) begin : g_cmp
         assign care[gi] = (pat_ff[gi] != cst_pkg::LVL_X) &&
            (clk_src_sel != 5'(gi));
         assign match[gi] = care[gi] &&
            (pin_s[gi] == (pat_ff[gi] == cst_pkg::LVL_HI));
         assign miss[gi] = care[gi] && !match[gi];
      end
   endgenerate

   // =========================================
   // boolean function and edge detect
   always_comb begin
      any_care = |care;
      clk_now = (clk_src_sel <= cst_pkg::IDX_LAST) ?
         pin_s[clk_src_sel] : 1'b0;
      edge_hit = rise_ff ? (clk_now && !clk_prev_ff) :
         (!clk_now && clk_prev_ff);
      case (cst_pkg::cst_func_e'(func_sel))
         cst_pkg::CST_AND: fn_true = (match == care);
         cst_pkg::CST_NAND: fn_true = |miss;
         cst_pkg::CST_OR: fn_true = |match;
         cst_pkg::CST_NOR: fn_true = (miss == care);
         default: fn_true = 1'b0;
      endcase
   end

   // =========================================
   // pattern store and pointer
   always_comb begin
      wr_any = set_high_cmd || set_low_cmd || clear_position_command;
      wr_lvl = set_high_cmd ? cst_pkg::LVL_HI :
         (set_low_cmd ? cst_pkg::LVL_LO : cst_pkg::LVL_X);
      nxt_pat = pat_ff;
      nxt_ptr = ptr_ff;
      if (ptr_load) begin
         nxt_ptr = (ptr_load_val > cst_pkg::IDX_LAST) ?
            cst_pkg::IDX_LAST : ptr_load_val;
      end else if (wr_any) begin
         nxt_pat[ptr_ff] = wr_lvl;
         nxt_ptr = (ptr_ff == cst_pkg::IDX_FIRST) ? cst_pkg::IDX_LAST :
            ptr_ff - 5'h01;
      end
      nxt_rise = polarity_cmd ? !rise_ff : rise_ff;
   end

   // =========================================
   // trigger, holdoff and auto timeout
   always_comb begin
      // settings above full scale are held at full scale
      hold_pct = (holdoff_pct > cst_pkg::PCT_MAX) ? cst_pkg::PCT_MAX :
         holdoff_pct;
      nxt_clk_prev = clk_now;
      nxt_trig = 1'b0;
      nxt_acq = 1'b0;
      nxt_hold = hold_ff;
      nxt_auto = auto_ff;
      if (hold_ff != '0) begin
         nxt_hold = hold_ff - 1'b1;
      end else if (edge_hit && any_care && fn_true) begin
         nxt_trig = 1'b1;
      end
      if (nxt_trig) begin
         nxt_hold = CNT_W'(hold_pct) * STEP_CYC;
         nxt_acq = 1'b1;
         nxt_auto = AUTO_LOAD;
      end else if (auto_mode && hold_ff == '0) begin
         if (auto_ff == '0) begin
            nxt_acq = 1'b1;
            nxt_auto = AUTO_LOAD;
         end else begin
            nxt_auto = auto_ff - 1'b1;
         end
      end else begin
         nxt_auto = AUTO_LOAD;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < cst_pkg::NUM_IN; i++) begin
            pat_ff[i] <= cst_pkg::LVL_X;
         end
         ptr_ff <= cst_pkg::IDX_LAST;
         rise_ff <= 1'b1;
         clk_prev_ff <= 1'b0;
         hold_ff <= '0;
         auto_ff <= '0;
         trig_ff <= 1'b0;
         acq_ff <= 1'b0;
      end else begin
         pat_ff <= nxt_pat;
         ptr_ff <= nxt_ptr;
         rise_ff <= nxt_rise;
         clk_prev_ff <= nxt_clk_prev;
         hold_ff <= nxt_hold;
         auto_ff <= nxt_auto;
         trig_ff <= nxt_trig;
         acq_ff <= nxt_acq;
      end
   end

   assign pattern_position_pointer = ptr_ff;
   assign rising_edge_sel = rise_ff;
   assign trigger_pulse = trig_ff;
   assign acquire_start = acq_ff;
   assign holdoff_busy = (hold_ff != '0);
   assign pattern_valid = any_care;

   // =========================================
   // checks
   a_no_trig_holdoff: assert property (@(posedge core_clk)
      disable iff (!reset_n) (hold_ff != '0) |=> !trig_ff)
      else $error("trigger during holdoff");
   a_trig_needs_edge: assert property (@(posedge core_clk)
      disable iff (!reset_n) trig_ff |-> $past(edge_hit))
      else $error("trigger without clock edge");
   a_trig_now: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (hold_ff == '0 && edge_hit && any_care && fn_true) |=> trig_ff)
      else $error("trigger delayed");
   a_all_x_quiet: assert property (@(posedge core_clk)
      disable iff (!reset_n) !any_care |=> !trig_ff)
      else $error("trigger with empty pattern");
   a_and_func: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (func_sel == 2'h0 && any_care) |-> (fn_true == ((match | ~care) == '1)))
      else $error("and function wrong");
   a_nor_func: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (func_sel == 2'h2) |-> (fn_true == (match == '0)))
      else $error("nor function wrong");
   a_ptr_decr: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (wr_any && !ptr_load && ptr_ff != 5'h00) |=>
      (ptr_ff == $past(ptr_ff) - 5'h01))
      else $error("pointer not decremented");
   a_pol_toggle: assert property (@(posedge core_clk)
      disable iff (!reset_n) polarity_cmd |=> (rise_ff != $past(rise_ff)))
      else $error("polarity did not toggle");
   a_normal_acq: assert property (@(posedge core_clk)
      disable iff (!reset_n) (acq_ff && !$past(auto_mode)) |-> trig_ff)
      else $error("forced acquire in normal mode");
   a_clk_masked: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (clk_src_sel <= 5'h10) |-> !care[clk_src_sel])
      else $error("clock source compared");
endmodule : cst_trigger

// [cst_pkg.sv]
// cst_pkg.sv: constants for the clocked state trigger.
// assumes one 125 MHz core clock; no bus, all settings are plain ports.
package cst_pkg;
   // =========================================
   // input and pattern layout
   localparam int NUM_IN = 17;
   localparam int IDX_W = 5;
   localparam logic [4:0] IDX_LAST = 5'h10;
   localparam logic [4:0] IDX_FIRST = 5'h00;
   // two-bit level code per pattern position
   localparam logic [1:0] LVL_X = 2'h0;
   localparam logic [1:0] LVL_LO = 2'h1;
   localparam logic [1:0] LVL_HI = 2'h2;
   // =========================================
   // boolean functions
   typedef enum logic [1:0] {
      CST_AND = 2'h0,
      CST_NAND = 2'h1,
      CST_OR = 2'h3,
      CST_NOR = 2'h2
   } cst_func_e;
   // =========================================
   // timing
   localparam int CLK_MHZ = 125;
   localparam int HOLDOFF_STEP_NS = 80;
   localparam int HOLDOFF_STEP_CYC =
      (HOLDOFF_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int AUTO_TIMEOUT_US = 100;
   localparam int AUTO_TIMEOUT_CYC = AUTO_TIMEOUT_US * CLK_MHZ;
   localparam logic [6:0] PCT_MAX = 7'h64;
endpackage : cst_pkg

// [cst_sync.sv]
// cst_sync.sv: two-flop synchroniser for a vector of pin inputs.
// assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module cst_sync #(
   parameter int W = 17
) (
   core_clk,
   reset_n,
   async_in,
   sync_out
);
   input wire logic core_clk;
   input wire logic reset_n;
   input wire logic [W-1:0] async_in;
   output logic [W-1:0] sync_out;

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // =========================================
   // two stages, first only feeds second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule : cst_sync

// [cst_src_model.sv]
// cst_src_model.sv: circuit under test that drives the probed pins.
// assumes the bench sets data as a level and calls edge_to for clocks.
`timescale 1ns/1ns
module cst_src_model (
   clk_idx,
   data,
   probe
);
   input wire logic [4:0] clk_idx;
   input wire logic [16:0] data;
   output logic [16:0] probe;
   logic clk_lvl = 1'b0;
   // ======================================
   // clock bit overrides data, still between edges
   always_comb begin
      probe = data;
      probe[clk_idx] = clk_lvl;
   end
   // one link clock edge, 80 ns period
   task edge_to(input logic d);
      clk_lvl = ~d;
      #40;
      clk_lvl = d;
      #40;
   endtask : edge_to
endmodule : cst_src_model

// [cst_trigger_bench.sv]
// cst_trigger_bench.sv: self-checking bench for the state trigger.
// assumes cst_src_model drives the probes; auto timeout shortened to 50.
`timescale 1ns/1ns
module cst_trigger_bench;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [16:0] probe_in, dat = 17'h0;
   logic [4:0] clk_src_sel = 5'h10, ptr_load_val = 5'h0;
   logic [1:0] func_sel = 2'h0;
   logic [6:0] holdoff_pct = 7'h0;
   logic polarity_cmd = 0, auto_mode = 0, ptr_load = 0;
   logic set_high_cmd = 0, set_low_cmd = 0, clear_position_command = 0;
   logic [4:0] pattern_position_pointer;
   logic rising_edge_sel, trigger_pulse, acquire_start;
   logic holdoff_busy, pattern_valid;
   int error_cnt = 0, n_tests = 0, trig_cnt = 0, acq_cnt = 0, cyc = 0;
   int a_base = 0;
   cst_pkg::cst_func_e fl[4] = '{cst_pkg::CST_AND, cst_pkg::CST_NAND,
      cst_pkg::CST_OR, cst_pkg::CST_NOR};
   logic [1:0] dv[3] = '{2'h2, 2'h3, 2'h1};
   logic ex;
   cst_trigger #(.AUTO_CYC(50)) dut (.core_clk(core_clk),
      .reset_n(reset_n), .probe_in(probe_in), .clk_src_sel(clk_src_sel),
      .polarity_cmd(polarity_cmd), .func_sel(func_sel),
      .auto_mode(auto_mode), .holdoff_pct(holdoff_pct),
      .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
      .set_high_cmd(set_high_cmd), .set_low_cmd(set_low_cmd),
      .clear_position_command(clear_position_command),
      .pattern_position_pointer(pattern_position_pointer),
      .rising_edge_sel(rising_edge_sel), .trigger_pulse(trigger_pulse),
      .acquire_start(acquire_start), .holdoff_busy(holdoff_busy),
      .pattern_valid(pattern_valid));
   cst_src_model src (.clk_idx(clk_src_sel), .data(dat), .probe(probe_in));
   // ======================================
   // clock, pulse counters and hang limit
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   // pulses counted mid-cycle, where they have settled
   always @(negedge core_clk) begin
      cyc++;
      if (trigger_pulse === 1'b1) trig_cnt++;
      if (acquire_start === 1'b1) acq_cnt++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // command pulses: bit0 high, 1 low, 2 dont-care, 3 polarity
   task pulse(input logic [3:0] c);
      @(posedge core_clk) #1;
      {polarity_cmd, clear_position_command, set_low_cmd, set_high_cmd} = c;
      @(posedge core_clk) #1;
      {polarity_cmd, clear_position_command, set_low_cmd, set_high_cmd} = 0;
   endtask : pulse
   task ptr(input logic [4:0] v);
      @(posedge core_clk) #1;
      ptr_load = 1;
      ptr_load_val = v;
      @(posedge core_clk) #1;
      ptr_load = 0;
   endtask : ptr
   // one clock edge, then count triggers and acquisitions
   task fire(input logic d, input logic [7:0] exp);
      int t0, a0;
      @(posedge core_clk) #1;
      t0 = trig_cnt;
      a0 = acq_cnt;
      src.edge_to(d);
      repeat (6) @(posedge core_clk);
      chk(8'(trig_cnt - t0), exp);
      chk(8'(acq_cnt - a0), exp);
   endtask : fire
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // ======================================
   // main sequence
   initial begin
      repeat (5) @(posedge core_clk);
      #1 reset_n = 1;
      chk({3'h0, pattern_position_pointer}, 8'h10);
      chk({7'h0, rising_edge_sel}, 8'h1);
      fire(1, 0);
      chk({7'h0, pattern_valid}, 8'h0);
      repeat (100) @(posedge core_clk);
      chk(8'(acq_cnt), 8'h0);
      ptr(0);
      pulse(1);
      chk({3'h0, pattern_position_pointer}, 8'h10);
      ptr(1);
      pulse(2);
      chk({3'h0, pattern_position_pointer}, 8'h0);
      ptr(5'h1f);
      chk({3'h0, pattern_position_pointer}, 8'h10);
      chk({7'h0, pattern_valid}, 8'h1);
      for (int f = 0; f < 4; f++) begin
         for (int m = 0; m < 3; m++) begin
            @(posedge core_clk) #1;
            func_sel = fl[f];
            dat = {15'h0, dv[m]};
            ex = (f == 0) ? (m == 2) : (f == 1) ? (m != 2) :
               (f == 2) ? (m != 0) : (m == 0);
            fire(1, {7'h0, ex});
         end
      end
      @(posedge core_clk) #1;
      func_sel = cst_pkg::CST_AND;
      dat = 17'h1;
      clk_src_sel = 5'h0;
      pulse(8);
      chk({7'h0, rising_edge_sel}, 8'h0);
      fire(0, 1);
      pulse(8);
      chk({7'h0, rising_edge_sel}, 8'h1);
      @(posedge core_clk) #1;
      clk_src_sel = 5'h10;
      holdoff_pct = 7'h5;
      repeat (4) @(posedge core_clk);
      fire(1, 1);
      fire(1, 0);
      chk({7'h0, holdoff_busy}, 8'h1);
      repeat (60) @(posedge core_clk);
      chk({7'h0, holdoff_busy}, 8'h0);
      fire(1, 1);
      repeat (60) @(posedge core_clk);
      #1 auto_mode = 1;
      a_base = acq_cnt;
      repeat (40) @(posedge core_clk);
      chk(8'(acq_cnt - a_base), 8'h0);
      repeat (30) @(posedge core_clk);
      chk(8'(acq_cnt - a_base), 8'h1);
      ptr(1);
      pulse(4);
      pulse(4);
      chk({7'h0, pattern_valid}, 8'h0);
      chk({3'h0, pattern_position_pointer}, 8'h10);
      tally_and_finish();
   end
endmodule : cst_trigger_bench
